//--- logic/egm_cfg.svh
`ifndef EGM_CFG_SVH
`define EGM_CFG_SVH
// =====================================================
// Register map and field layout.
// =====================================================
`define EGM_ADDR_MAIN_CTRL0   11'h400
`define EGM_ADDR_WIN_LAST     11'h03F
`define EGM_MAIN_CTRL_RESET   8'h00
`define EGM_BIT_WR_ALL        7
`define EGM_BIT_OUT_EN        6
`define EGM_BIT_IRQ_MASK      5
`define EGM_BIT_TONE_B_MASK   4
`define EGM_BIT_TONE_A_MASK   3
`define EGM_BIT_FORMAT        2
`define EGM_BIT_LAW           1
`define EGM_BIT_POWER_UP      0
// =====================================================
// Timing, counted in PCM frames.
// =====================================================
`define EGM_INIT_FRAMES       2
`define EGM_BYPASS_FRAMES     2
`endif

//--- logic/egm_pkg.sv
// =====================================================
// Shared types.
// =====================================================
package egm_pkg;
	// Initialization sequencer states.
	typedef enum logic [1:0] {
		EGM_IDLE,
		EGM_INIT,
		EGM_READY
	} egm_init_e;
endpackage

//--- logic/egm_ctrl_if.sv
// =====================================================
// Control bundle between the register and the sequencer.
// =====================================================
interface egm_ctrl_if;
	logic power_up;   // Group power-up bit.
	logic frame_tick; // One-cycle pulse per PCM frame.
	logic init_busy;  // Initialization running.
	logic init_start; // Pulse on power-up rising edge.
	modport reg_side (output power_up, output frame_tick, input init_busy, input init_start);
	modport seq_side (input power_up, input frame_tick, output init_busy, output init_start);
endinterface

//--- logic/egm_init_seq.sv
`include "egm_cfg.svh"
// =====================================================
// Initialization sequencer, two frames long.
// =====================================================
module egm_init_seq (
	// Clock and reset.
	input  wire logic i_clk,
	input  wire logic i_resetn,
	// Control bundle.
	egm_ctrl_if.seq_side ctl
);
	egm_pkg::egm_init_e state;  // Sequencer state.
	logic               pwr_q;  // Previous power-up bit.
	logic [1:0]         frames; // Frames elapsed in init.
	logic               start;  // Rising edge of power-up.

	// Start on a zero-to-one transition of power-up.
	assign start = ctl.power_up & ~pwr_q; // see R10
	assign ctl.init_start = start;
	assign ctl.init_busy = (state == egm_pkg::EGM_INIT);

	// Edge history for power-up.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pwr_q <= 1'b0;
		end else begin
			pwr_q <= ctl.power_up;
		end
	end

	// Sequencer: runs init for two frames, then ready.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state  <= egm_pkg::EGM_IDLE;
			frames <= 2'h0;
		end else begin
			case (state)
				egm_pkg::EGM_IDLE: begin
					if (start) begin
						state  <= egm_pkg::EGM_INIT;
						frames <= 2'h0;
					end
				end
				egm_pkg::EGM_INIT: begin
					if (!ctl.power_up) begin
						state <= egm_pkg::EGM_IDLE;
					end else if (ctl.frame_tick) begin
						if (frames == 2'(`EGM_INIT_FRAMES - 1)) begin
							state <= egm_pkg::EGM_READY; // see R11
						end
						frames <= frames + 2'h1;
					end
				end
				default: begin
					if (!ctl.power_up) begin
						state <= egm_pkg::EGM_IDLE;
					end
				end
			endcase
		end
	end

	// Init always ends within two frames of starting.
	AST_INIT_ENDS: assert property (@(posedge i_clk) disable iff (!i_resetn) // see R11
		(state == egm_pkg::EGM_INIT && frames == 2'h2) |-> 1'b0) else $error("init overran");
endmodule

//--- logic/egm_main_ctrl.sv
`include "egm_cfg.svh"
// Functional notes
// R1: Broadcast bit aliases all groups onto group zero.
// R2: Broadcast, drive-enable, global mask only in group zero.
// R3: PCM outputs driven when bit and pin high.
// R4: Global mask suppresses all tone interrupts.
// R5: Canceller-B mask suppresses its tone interrupt.
// R6: Canceller-A mask suppresses its tone interrupt.
// R7: Format bit selects G.711 or sign-magnitude.
// R8: Law bit selects A-law or mu-law.
// R9: Power-down bypasses PCM with two-frame delay.
// R10: Power-up rising edge starts canceller initialization.
// R11: Initialization takes two frames; host waits.
// R12: Interrupt passes only when both masks clear.
// R13: Register reads back, resets to zero.
module egm_main_ctrl #(
	parameter int FRAME_CYCLES = 1250 // Master clocks per 125 us PCM frame at 10 MHz.
) (
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	// Microprocessor port.
	input  wire logic [10:0] i_addr,
	input  wire logic        i_cs,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [7:0]  i_wdata,
	output logic      [7:0]  o_rdata,
	// Pins.
	input  wire logic        i_out_en_pin,
	// Tone-detector interrupt requests.
	input  wire logic        i_tone_a_irq,
	input  wire logic        i_tone_b_irq,
	// PCM bypass path, one sample per frame.
	input  wire logic [7:0]  i_rin,
	input  wire logic [7:0]  i_sin,
	output logic      [7:0]  o_rout,
	output logic      [7:0]  o_sout,
	output logic             o_pcm_oe,
	// Status to the cancellers.
	output logic             o_irq,
	output logic             o_broadcast,
	output logic             o_g711,
	output logic             o_a_law,
	output logic             o_power_up,
	output logic             o_init_busy
);
	// =====================================================
	// Register and synchronisers.
	// =====================================================
	logic [7:0]  main_ctrl;            // Group-zero main control register.
	logic [1:0]  pin_sync;             // Output-enable pin synchroniser.
	logic [1:0]  ta_sync;              // Tone A synchroniser.
	logic [1:0]  tb_sync;              // Tone B synchroniser.
	logic [10:0] frame_cnt;            // Frame divider.
	logic [7:0]  rin_d [`EGM_BYPASS_FRAMES]; // Receive bypass delay line.
	logic [7:0]  sin_d [`EGM_BYPASS_FRAMES]; // Send bypass delay line.
	logic        tone_a_ok;            // Tone A after its own mask.
	logic        tone_b_ok;            // Tone B after its own mask.
	egm_ctrl_if  ctl ();

	// Host write; all bits of the group-zero register are held.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			main_ctrl <= `EGM_MAIN_CTRL_RESET; // see R13
		end else if (i_cs && i_wr && i_addr == `EGM_ADDR_MAIN_CTRL0) begin
			main_ctrl <= i_wdata; // see R2
		end
	end

	// Read back; unmapped addresses read zero.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= 8'h00;
		end else if (i_cs && i_rd && i_addr == `EGM_ADDR_MAIN_CTRL0) begin
			o_rdata <= main_ctrl; // see R13
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// Two-flop synchronisers for outside inputs.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_sync <= 2'h0;
			ta_sync  <= 2'h0;
			tb_sync  <= 2'h0;
		end else begin
			pin_sync <= {pin_sync[0], i_out_en_pin};
			ta_sync  <= {ta_sync[0], i_tone_a_irq};
			tb_sync  <= {tb_sync[0], i_tone_b_irq};
		end
	end

	// =====================================================
	// Frame divider.
	// =====================================================
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			frame_cnt <= 11'h000;
		end else if (frame_cnt == 11'(FRAME_CYCLES - 1)) begin
			frame_cnt <= 11'h000;
		end else begin
			frame_cnt <= frame_cnt + 11'h001;
		end
	end
	assign ctl.frame_tick = (frame_cnt == 11'(FRAME_CYCLES - 1));
	assign ctl.power_up = main_ctrl[`EGM_BIT_POWER_UP];

	egm_init_seq egm_init_seq_inst (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.ctl      (ctl)
	);

	// =====================================================
	// Interrupt masking.
	// =====================================================
	assign tone_a_ok = ta_sync[1] & ~main_ctrl[`EGM_BIT_TONE_A_MASK]; // see R6
	assign tone_b_ok = tb_sync[1] & ~main_ctrl[`EGM_BIT_TONE_B_MASK]; // see R5

	// Interrupt output, gated by the global mask and power state.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= ~main_ctrl[`EGM_BIT_IRQ_MASK] & main_ctrl[`EGM_BIT_POWER_UP]
				& (tone_a_ok | tone_b_ok); // see R4 R12
		end
	end

	// =====================================================
	// Mode outputs.
	// =====================================================
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_broadcast <= 1'b0;
			o_g711      <= 1'b0;
			o_a_law     <= 1'b0;
			o_power_up  <= 1'b0;
			o_init_busy <= 1'b0;
			o_pcm_oe    <= 1'b0;
		end else begin
			o_broadcast <= main_ctrl[`EGM_BIT_WR_ALL]; // see R1
			o_g711      <= main_ctrl[`EGM_BIT_FORMAT]; // see R7
			o_a_law     <= main_ctrl[`EGM_BIT_LAW]; // see R8
			// The start pulse is masked too, so power-up never flashes high before init.
			o_power_up  <= main_ctrl[`EGM_BIT_POWER_UP] & ~ctl.init_busy & ~ctl.init_start; // see R10
			o_init_busy <= ctl.init_busy | ctl.init_start; // see R11
			o_pcm_oe    <= main_ctrl[`EGM_BIT_OUT_EN] & pin_sync[1]; // see R3
		end
	end

	// =====================================================
	// Power-down bypass, two frames of delay.
	// =====================================================
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int i = 0; i < `EGM_BYPASS_FRAMES; i++) begin
				rin_d[i] <= 8'h00;
				sin_d[i] <= 8'h00;
			end
			o_rout <= 8'h00;
			o_sout <= 8'h00;
		end else if (ctl.frame_tick) begin
			rin_d[0] <= i_rin;
			sin_d[0] <= i_sin;
			for (int i = 1; i < `EGM_BYPASS_FRAMES; i++) begin
				rin_d[i] <= rin_d[i-1];
				sin_d[i] <= sin_d[i-1];
			end
			// While powered the datapath owns the outputs; here they rest at zero.
			o_rout <= main_ctrl[`EGM_BIT_POWER_UP] ? 8'h00 : rin_d[`EGM_BYPASS_FRAMES-1]; // see R9
			o_sout <= main_ctrl[`EGM_BIT_POWER_UP] ? 8'h00 : sin_d[`EGM_BYPASS_FRAMES-1]; // see R9
		end
	end

	// =====================================================
	// Checks.
	// =====================================================
	// The drive enable follows the register bit and the synced pin one cycle later.
	AST_OE_AND: assert property (@(posedge i_clk) disable iff (!i_resetn) // see R3
		##1 o_pcm_oe == $past(main_ctrl[`EGM_BIT_OUT_EN] & pin_sync[1])) else $error("oe gating wrong");
	// The global mask silences the interrupt from the next cycle on.
	AST_GMASK: assert property (@(posedge i_clk) disable iff (!i_resetn) // see R4
		$past(main_ctrl[`EGM_BIT_IRQ_MASK]) |-> !o_irq) else $error("global mask leak");
	// Canceller B masked while canceller A is quiet leaves no interrupt.
	AST_BMASK: assert property (@(posedge i_clk) disable iff (!i_resetn) // see R5
		($past(main_ctrl[`EGM_BIT_TONE_B_MASK]) && !$past(ta_sync[1])) |-> !o_irq) else $error("b mask leak");
	// Canceller A masked while canceller B is quiet leaves no interrupt.
	AST_AMASK: assert property (@(posedge i_clk) disable iff (!i_resetn) // see R6
		($past(main_ctrl[`EGM_BIT_TONE_A_MASK]) && !$past(tb_sync[1])) |-> !o_irq) else $error("a mask leak");
	// With every mask clear and the group powered, a tone A request must pass.
	AST_IRQ_PASS: assert property (@(posedge i_clk) disable iff (!i_resetn) // see R12
		(main_ctrl[5:3] == 3'h0 && main_ctrl[`EGM_BIT_POWER_UP] && ta_sync[1]) |=> o_irq) else $error("irq lost");
	// A powered-down group raises no interrupt, since its detectors are off.
	AST_IRQ_DOWN: assert property (@(posedge i_clk) disable iff (!i_resetn) // see R9
		!$past(main_ctrl[`EGM_BIT_POWER_UP]) |-> !o_irq) else $error("irq while powered down");
	// The coding mode outputs copy their bits one cycle late.
	AST_FMT: assert property (@(posedge i_clk) disable iff (!i_resetn) // see R7
		##1 (o_g711 == $past(main_ctrl[2]) && o_a_law == $past(main_ctrl[1]))) else $error("mode wrong");
	// A host write lands in the register on the next edge.
	AST_WRITE: assert property (@(posedge i_clk) disable iff (!i_resetn) // see R13
		(i_cs && i_wr && i_addr == `EGM_ADDR_MAIN_CTRL0) |=> main_ctrl == $past(i_wdata)) else $error("write lost");
	// A read of the register returns its value one cycle later.
	AST_READ: assert property (@(posedge i_clk) disable iff (!i_resetn) // see R13
		(i_cs && i_rd && i_addr == `EGM_ADDR_MAIN_CTRL0) |=> o_rdata == $past(main_ctrl)) else $error("read data wrong");
	// Any other cycle leaves the read bus at zero.
	AST_READ_IDLE: assert property (@(posedge i_clk) disable iff (!i_resetn) // see R2
		!(i_cs && i_rd && i_addr == `EGM_ADDR_MAIN_CTRL0) |=> o_rdata == 8'h00) else $error("read bus not idle");
	// A rising power-up bit starts initialization.
	AST_INIT_GO: assert property (@(posedge i_clk) disable iff (!i_resetn) // see R10
		$rose(main_ctrl[`EGM_BIT_POWER_UP]) |=> o_init_busy) else $error("init not started");
	// The group never reports itself powered while initialization runs.
	AST_PWR_QUIET: assert property (@(posedge i_clk) disable iff (!i_resetn) // see R11
		o_init_busy |-> !o_power_up) else $error("powered during init");
	// The bypass outputs move only on a frame tick.
	AST_BYPASS_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn) // see R9
		!ctl.frame_tick |=> ($stable(o_rout) && $stable(o_sout))) else $error("bypass moved off tick");
	// The broadcast mapping output follows its bit one cycle late.
	AST_BCAST: assert property (@(posedge i_clk) disable iff (!i_resetn) // see R1
		##1 o_broadcast == $past(main_ctrl[7])) else $error("broadcast wrong");
endmodule

//--- tb/egm_host.sv
// =====================================================
// Host processor model on the parallel port.
// =====================================================
module egm_host (
	// Clock and read data.
	input  wire logic        i_clk,
	input  wire logic [7:0]  i_rdata,
	// Bus strobes and data.
	output logic      [10:0] o_addr,
	output logic             o_cs,
	output logic             o_wr,
	output logic             o_rd,
	output logic      [7:0]  o_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// The bus idles deselected.
	initial begin
		o_addr = 11'h000;
		o_wdata = 8'h00;
		o_cs = 1'b0;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// One access, held over one rising edge; read data is taken at the next falling edge.
	task automatic xfer(input logic [10:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
		@(negedge i_clk);
		o_addr = a;
		o_wdata = d;
		o_cs = 1'b1;
		o_wr = w;
		o_rd = !w;
		@(posedge i_clk);
		@(negedge i_clk);
		q = i_rdata;
		o_cs = 1'b0;
		o_wr = 1'b0;
		o_rd = 1'b0;
		// Released lines show the inverse so stale values cannot pass.
		o_addr = ~a;
		o_wdata = ~d;
	endtask
endmodule

//--- tb/egm_main_ctrl_tb.sv
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); err_total++; end end
// =====================================================
// Bench for the group-zero main control register.
// =====================================================
module egm_main_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FRM = 8; // Short frame for simulation.
	logic        clk, rstn, pin, ta, tb, cs, wr, rd, oe, irq, bc, g7, al, pu, busy;
	logic [10:0] addr;
	logic [7:0]  wd, rdat, rin, sin, rout, sout, q;
	int          err_total, num_checks, cyc, n;
	// =====================================================
	// Design and host.
	// =====================================================
	egm_main_ctrl #(.FRAME_CYCLES(FRM)) egm_main_ctrl_inst (.i_clk(clk), .i_resetn(rstn), .i_addr(addr),
		.i_cs(cs), .i_wr(wr), .i_rd(rd), .i_wdata(wd), .o_rdata(rdat), .i_out_en_pin(pin),
		.i_tone_a_irq(ta), .i_tone_b_irq(tb), .i_rin(rin), .i_sin(sin), .o_rout(rout), .o_sout(sout),
		.o_pcm_oe(oe), .o_irq(irq), .o_broadcast(bc), .o_g711(g7), .o_a_law(al), .o_power_up(pu),
		.o_init_busy(busy));
	egm_host egm_host_inst (.i_clk(clk), .i_rdata(rdat), .o_addr(addr), .o_cs(cs), .o_wr(wr), .o_rd(rd),
		.o_wdata(wd));
	// =====================================================
	// Helpers.
	// =====================================================
	// Prints the verdict and ends the run.
	task automatic summarize();
		if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wreg(input logic [10:0] a, input logic [7:0] d);
		egm_host_inst.xfer(a, 1'b1, d, q);
	endtask
	task automatic rreg(input logic [10:0] a, input logic [7:0] e);
		egm_host_inst.xfer(a, 1'b0, 8'h00, q);
		`CHK(q, e)
	endtask
	task automatic settle(input int c);
		repeat (c) @(negedge clk);
	endtask
	// Clock of 100 ns period.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			summarize();
		end
	end
	// =====================================================
	// Tests.
	// =====================================================
	initial begin
		{rstn, pin, ta, tb, rin, sin} = '0;
		settle(5);
		rstn = 1'b1;
		rreg(11'h400, 8'h00);
		`CHK(oe, 1'b0)
		wreg(11'h400, 8'hFE);
		rreg(11'h400, 8'hFE);
		rreg(11'h401, 8'h00);
		settle(2);
		`CHK({bc, g7, al, pu}, 4'hE)
		wreg(11'h400, 8'h00);
		settle(2);
		`CHK({bc, g7, al}, 3'h0)
		// Drive enable needs both the bit and the pin.
		for (int i = 0; i < 4; i++) begin
			wreg(11'h400, i[1] ? 8'h40 : 8'h00);
			pin = i[0];
			settle(5);
			`CHK(oe, i[1] & i[0])
		end
		// Bypass while powered down, two frames late.
		rin = 8'h3C;
		sin = 8'hC3;
		settle(4 * FRM);
		`CHK({rout, sout}, 16'h3CC3)
		rin = 8'h5A;
		sin = 8'hA5;
		settle(2 * FRM - 1);
		`CHK({rout, sout}, 16'h3CC3)
		settle(FRM + 4);
		`CHK({rout, sout}, 16'h5AA5)
		// Power-up starts a two-frame initialization.
		wreg(11'h400, 8'h01);
		settle(2);
		`CHK({busy, pu}, 2'b10)
		n = 0;
		while (busy === 1'b1 && n < 4 * FRM) begin
			settle(1);
			n++;
		end
		`CHK(n > FRM - 3 && n <= 2 * FRM + 2, 1'b1)
		`CHK(pu, 1'b1)
		// Every mask and tone combination.
		for (int i = 0; i < 32; i++) begin
			wreg(11'h400, {2'b00, i[4:2], 3'b001});
			ta = i[0];
			tb = i[1];
			settle(5);
			`CHK(irq, !i[4] && ((i[0] && !i[2]) || (i[1] && !i[3])))
			`CHK(busy, 1'b0)
		end
		wreg(11'h401, 8'hFF);
		rreg(11'h400, 8'h39);
		// Reset in mid-run clears the register.
		rstn = 1'b0;
		settle(2);
		`CHK({oe, irq, pu}, 3'h0)
		rstn = 1'b1;
		rreg(11'h400, 8'h00);
		summarize();
	end
endmodule
